//--- src/kbhm_pkg.sv
// Constants, types and structs for the keyboard host mailbox.
// Assumes a single 10 MHz clock shared by host port and embedded core.
package kbhm_pkg;

	// Host I/O addresses
	localparam logic [15:0] KBHM_DATA_PORT_ADDR = 16'h0060;
	localparam logic [15:0] KBHM_CTL_PORT_ADDR  = 16'h0064;
	localparam int          KBHM_ADDR_CD_BIT    = 2;

	// Status register field positions
	localparam int KBHM_ST_OBF = 0;
	localparam int KBHM_ST_IBF = 1;
	localparam int KBHM_ST_UD2 = 2;
	localparam int KBHM_ST_CD  = 3;
	localparam int KBHM_ST_UDH = 4;

	// Mask of firmware-writable status bits (7..4 and 2)
	localparam logic [7:0] KBHM_ST_UD_MASK = 8'hF4;

	// Reset values
	localparam logic [7:0] KBHM_STATUS_RST = 8'h00;
	localparam logic [7:0] KBHM_DATA_RST   = 8'h00;
	localparam logic       KBHM_PORT_RST   = 1'b0;
	localparam logic [2:0] KBHM_QUASI_RST  = 3'h7;

	// Quasi-bidirectional active-high drive time
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int QUASI_DRIVE_NS  = 500;
	localparam int QUASI_DRIVE_CYC = (QUASI_DRIVE_NS / CLOCK_PERIOD_NS < 1)
		? 1 : QUASI_DRIVE_NS / CLOCK_PERIOD_NS;
	localparam logic [3:0] QUASI_DRIVE_CNT = 4'(QUASI_DRIVE_CYC);

	// Open-drain pin count and order: kb clk, kb dat, ms clk, ms dat
	localparam int KBHM_NPINS = 4;
	localparam int KBHM_NQ    = 3;

	// Core power states
	typedef enum logic [2:0] {
		PWR_RUN  = 3'b001,
		PWR_HALT = 3'b010,
		PWR_STOP = 3'b100
	} kbhm_pwr_e;

	// Host I/O cycle, one-cycle strobes
	typedef struct packed {
		logic        write;
		logic        read;
		logic [15:0] addr;
		logic [7:0]  data;
	} kbhm_host_req_s;

	// Core port 2 output bits
	typedef struct packed {
		logic port_bit_kbdat;
		logic port_bit_kbclk;
		logic port_bit_aux_irq_out;
		logic port_bit_kbd_irq_out;
		logic port_bit_msclk;
		logic port_bit_msdat;
		logic port_bit_a20;
	} kbhm_port2_s;

endpackage

//--- src/kbhm_mailbox.sv
// Keyboard host mailbox: host data/command/status registers, core
// mailbox side, interrupt gating, keyboard/mouse pins and power-down.
// Assumes host cycles and core strobes are one-cycle pulses on clock.
//
// What this block does
// RL1 - Host write at data address loads input register as data; read gives output
// RL2 - Host write at command address loads input as command; read gives status
// RL3 - Host data write clears command/data bit and sets input full
// RL4 - Host command write sets command/data bit and sets input full
// RL5 - With flags enabled, host data read clears output full and keyboard irq
// RL6 - Core write of output register sets output full, status bit 0
// RL7 - Host write copies address bit 2 into status bit 3
// RL8 - Flags enabled: keyboard irq is output full gated by its port bit
// RL9 - Flags disabled: keyboard irq follows its port bit directly
// RL10 - After reset the keyboard irq output is low
// RL11 - Flags enabled, port bit one: mouse irq shows inverted input full
// RL12 - Flags disabled: mouse irq follows its port bit directly
// RL13 - Port bit drives gate-A20 output under software control
// RL14 - Quasi pins drive low for zero; for one drive high briefly, then release
// RL15 - Open-drain configuration: low for zero, tristate for one, no pulse
// RL16 - Controller mode pins ignore input or invert configuration
// RL17 - Keyboard/mouse pins driven inverted, read back on test and port inputs
// RL18 - Halt stops ALU clock; reset or host write wakes, maybe via interrupt
// RL19 - Reset exit from power-down runs normal reset from address 0
// RL20 - Stop kills oscillator and core clock; same exits; long reset needed
// RL21 - Core has two interrupt sources: input full and timer overflow
// RL22 - Core read of input register clears input full
// RL23 - Status clears on reset; firmware owns bits 7..4 and 2
`timescale 1ns/100ps

module kbhm_mailbox
	import kbhm_pkg::*;
(
	input  wire logic           clock,
	input  wire logic           rst,
	// Host side
	input  wire kbhm_host_req_s hostReq,
	output logic [7:0]          hostRdData,
	output logic                kbd_irq_out,
	output logic                aux_irq_out,
	output logic                gateA20,
	// Core mailbox side
	input  wire logic           coreWrOut,
	input  wire logic [7:0]     coreWrData,
	input  wire logic           coreRdIn,
	output logic [7:0]          core_input_reg,
	output logic [7:0]          coreStatus,
	input  wire logic           coreStatusWr,
	input  wire logic [7:0]     coreStatusData,
	input  wire logic           coreObfClr,
	input  wire logic           coreEnFlags,
	input  wire logic           port2Wr,
	input  wire kbhm_port2_s    port2Data,
	input  wire logic           port1Wr,
	input  wire logic [2:0]     port1Data,
	input  wire logic           openDrainMode,
	// Core interrupts and power
	input  wire logic           ibfIrqEn,
	input  wire logic           timerIrqEn,
	input  wire logic           timerOverflow,
	input  wire logic           coreHalt,
	input  wire logic           coreStop,
	output logic                coreIrqIbf,
	output logic                coreIrqTimer,
	output logic                wakeCall,
	output logic                coreRestart,
	output logic                aluRun,
	output logic                timerRun,
	output logic                oscRun,
	// Keyboard/mouse open-drain pins: kb clk, kb dat, ms clk, ms dat
	input  wire logic [3:0]     kmPinIn,
	output logic [3:0]          kmPinOut,
	output logic [3:0]          kmPinOeN,
	output logic                test_in_kbclk,
	output logic                port_in_kbdat,
	output logic                test_in_msclk,
	output logic                port_in_msdat,
	// Quasi-bidirectional pins: q17, q16, q12
	output logic [2:0]          quasiOut,
	output logic [2:0]          quasiOeN
);

	////////////////////////////////////////////////////////////////////
	// Host address decode

	logic hitData;
	logic hitCtl;
	logic hostWrHit;
	logic hostRdHit;
	logic hostRdStat;

	assign hitData    = hostReq.addr == KBHM_DATA_PORT_ADDR;
	assign hitCtl     = hostReq.addr == KBHM_CTL_PORT_ADDR;
	assign hostWrHit  = hostReq.write & (hitData | hitCtl);
	assign hostRdHit  = hostReq.read & hitData;
	assign hostRdStat = hostReq.read & hitCtl;

	////////////////////////////////////////////////////////////////////
	// Mailbox registers and flags

	logic [7:0] core_mailbox_reg;
	logic       input_full;
	logic       output_full;
	logic       cmdFlag;
	logic [7:0] userBits;
	logic       enFlags;
	logic [7:0] statusWord;

	logic       next_input_full;
	logic       next_output_full;
	logic       next_cmdFlag;
	logic       obfHostClr;

	// Host read clears output full only once flags are enabled
	assign obfHostClr = hostRdHit & enFlags;               // [RL5]

	// Set wins over clear on both full flags
	assign next_input_full  = hostWrHit                    // [RL3] [RL4]
		| (input_full & ~coreRdIn);                        // [RL22]
	assign next_output_full = coreWrOut                    // [RL6]
		| (output_full & ~obfHostClr & ~coreObfClr);       // [RL5]
	// Command/data bit follows host address bit 2 on every data or command write
	assign next_cmdFlag = hostWrHit
		? hostReq.addr[KBHM_ADDR_CD_BIT] : cmdFlag;        // [RL7] [RL3] [RL4]

	// Status word assembly
	always_comb begin
		statusWord = userBits & KBHM_ST_UD_MASK;           // [RL23]
		statusWord[KBHM_ST_OBF] = output_full;
		statusWord[KBHM_ST_IBF] = input_full;
		statusWord[KBHM_ST_CD]  = cmdFlag;
	end

	// Host write loads the input register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			core_input_reg <= KBHM_DATA_RST;
		end else if (hostWrHit) begin
			core_input_reg <= hostReq.data;                // [RL1] [RL2]
		end
	end

	// Core write loads the output register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			core_mailbox_reg <= KBHM_DATA_RST;
		end else if (coreWrOut) begin
			core_mailbox_reg <= coreWrData;                // [RL6]
		end
	end

	// Flags and firmware-owned status bits
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			input_full  <= 1'b0;                           // [RL23]
			output_full <= 1'b0;
			cmdFlag     <= 1'b0;
			userBits    <= KBHM_STATUS_RST;
			enFlags     <= 1'b0;
		end else begin
			input_full  <= next_input_full;
			output_full <= next_output_full;
			cmdFlag     <= next_cmdFlag;
			if (coreStatusWr) begin
				userBits <= coreStatusData & KBHM_ST_UD_MASK; // [RL23]
			end
			if (coreEnFlags) begin
				enFlags <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Host read data and core status view

	logic [7:0] next_hostRdData;
	logic [7:0] hostRdData_r;

	// Data read returns output register, status read the status
	assign next_hostRdData = hostRdHit ? core_mailbox_reg     // [RL1]
		: hostRdStat ? statusWord : hostRdData_r;             // [RL2]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hostRdData_r <= KBHM_STATUS_RST;
			coreStatus   <= KBHM_STATUS_RST;
		end else begin
			hostRdData_r <= next_hostRdData;
			coreStatus   <= statusWord;
		end
	end
	assign hostRdData = hostRdData_r;

	////////////////////////////////////////////////////////////////////
	// Port 2 latch: irq control, gate A20, keyboard/mouse drive

	kbhm_port2_s port2;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port2 <= '0;
		end else if (port2Wr) begin
			port2 <= port2Data;
		end
	end

	// Interrupt output gating
	logic next_kbd_irq_out;
	logic next_aux_irq_out;

	assign next_kbd_irq_out = enFlags
		? (port2.port_bit_kbd_irq_out & next_output_full)           // [RL8]
		: port2.port_bit_kbd_irq_out;                               // [RL9]
	assign next_aux_irq_out = enFlags
		? (port2.port_bit_aux_irq_out & ~next_input_full)           // [RL11]
		: port2.port_bit_aux_irq_out;                               // [RL12]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			kbd_irq_out <= 1'b0;                             // [RL10]
			aux_irq_out <= 1'b0;
			gateA20     <= KBHM_PORT_RST;
		end else begin
			kbd_irq_out <= next_kbd_irq_out;                        // [RL5]
			aux_irq_out <= next_aux_irq_out;
			gateA20     <= port2.port_bit_a20;               // [RL13]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Keyboard/mouse open-drain pins and read-back

	logic [3:0] kmDrive;
	logic [3:0] kmSync1;
	logic [3:0] kmSync2;
	logic [3:0] kmSync3;
	logic [3:0] kmLevel;

	// Port bit one pulls the pin low: output is the inverted bit
	assign kmDrive = {port2.port_bit_msdat, port2.port_bit_msclk,
		port2.port_bit_kbdat, port2.port_bit_kbclk};          // [RL17]

	genvar gp;
	generate
		for (gp = 0; gp < KBHM_NPINS; gp++) begin : gPin
			// Drive and synchronise one pin
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					kmPinOut[gp] <= 1'b0;
					kmPinOeN[gp] <= 1'b1;
					kmSync1[gp]  <= 1'b1;
					kmSync2[gp]  <= 1'b1;
					kmSync3[gp]  <= 1'b1;
					kmLevel[gp]  <= 1'b1;
				end else begin
					kmPinOut[gp] <= 1'b0;
					kmPinOeN[gp] <= ~kmDrive[gp];           // [RL17]
					kmSync1[gp]  <= kmPinIn[gp];
					kmSync2[gp]  <= kmSync1[gp];
					kmSync3[gp]  <= kmSync2[gp];
					if (kmSync2[gp] == kmSync3[gp]) begin
						kmLevel[gp] <= kmSync3[gp];
					end
				end
			end
		end
	endgenerate

	// Read-back routing to test inputs and port 1 bits
	assign test_in_kbclk = kmLevel[0];                       // [RL17]
	assign port_in_kbdat = kmLevel[1];
	assign test_in_msclk = kmLevel[2];
	assign port_in_msdat = kmLevel[3];

	////////////////////////////////////////////////////////////////////
	// Quasi-bidirectional port pins q17, q16, q12
	// Controller mode has no input or invert option, so none is taken.

	logic [2:0] port1;
	logic [3:0] quasiCnt [KBHM_NQ];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port1 <= KBHM_QUASI_RST;
		end else if (port1Wr) begin
			port1 <= port1Data;                              // [RL16]
		end
	end

	generate
		for (gp = 0; gp < KBHM_NQ; gp++) begin : gQuasi
			logic rising;
			assign rising = port1Wr & port1Data[gp] & ~port1[gp];
			// Pulse counter for the active-high drive window
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					quasiCnt[gp] <= 4'h0;
					quasiOut[gp] <= 1'b0;
					quasiOeN[gp] <= 1'b1;
				end else begin
					if (rising & ~openDrainMode) begin
						quasiCnt[gp] <= QUASI_DRIVE_CNT;     // [RL14]
					end else if (quasiCnt[gp] != 4'h0) begin
						quasiCnt[gp] <= quasiCnt[gp] - 4'h1;
					end
					if (~port1[gp]) begin
						quasiOut[gp] <= 1'b0;                // [RL14] [RL15]
						quasiOeN[gp] <= 1'b0;
					end else if (~openDrainMode
							&& quasiCnt[gp] > 4'h1) begin
						quasiOut[gp] <= 1'b1;                // [RL14]
						quasiOeN[gp] <= 1'b0;
					end else begin
						quasiOut[gp] <= 1'b0;                // [RL15]
						quasiOeN[gp] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Power-down control and core interrupts

	kbhm_pwr_e pwrState;
	kbhm_pwr_e next_pwrState;
	logic      wakeUp;

	assign wakeUp = hostWrHit & (pwrState != PWR_RUN);       // [RL18] [RL20]

	// Power state transitions
	always_comb begin
		next_pwrState = pwrState;
		unique case (pwrState)
			PWR_RUN: begin
				if (coreStop) begin
					next_pwrState = PWR_STOP;                // [RL20]
				end else if (coreHalt) begin
					next_pwrState = PWR_HALT;                // [RL18]
				end
			end
			PWR_HALT: begin
				if (hostWrHit) begin
					next_pwrState = PWR_RUN;                 // [RL18]
				end
			end
			PWR_STOP: begin
				if (hostWrHit) begin
					next_pwrState = PWR_RUN;                 // [RL20]
				end
			end
			default: begin
				next_pwrState = PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pwrState     <= PWR_RUN;                         // [RL19]
			coreRestart  <= 1'b1;                            // [RL19]
			wakeCall     <= 1'b0;
			aluRun       <= 1'b1;
			timerRun     <= 1'b1;
			oscRun       <= 1'b1;
			coreIrqIbf   <= 1'b0;
			coreIrqTimer <= 1'b0;
		end else begin
			pwrState     <= next_pwrState;
			coreRestart  <= 1'b0;
			wakeCall     <= wakeUp & ibfIrqEn;               // [RL18]
			aluRun       <= next_pwrState == PWR_RUN;        // [RL18]
			timerRun     <= next_pwrState != PWR_STOP;       // [RL20]
			oscRun       <= next_pwrState != PWR_STOP;       // [RL20]
			coreIrqIbf   <= ibfIrqEn & next_input_full;      // [RL21]
			coreIrqTimer <= timerIrqEn & timerOverflow;      // [RL21]
		end
	end

endmodule

//--- testbench/kbhm_mailbox_asserts.sv
// Concurrent checks on the keyboard host mailbox ports.
// Assumes a bind onto kbhm_mailbox with matching port names.
`timescale 1ns/100ps

module kbhm_mailbox_asserts
	import kbhm_pkg::*;
(
	input wire logic           clock,
	input wire logic           rst,
	input wire kbhm_host_req_s hostReq,
	input wire logic [7:0]     hostRdData,
	input wire logic           kbd_irq_out,
	input wire logic           aux_irq_out,
	input wire logic           gateA20,
	input wire logic           coreWrOut,
	input wire logic [7:0]     coreStatus,
	input wire logic           coreEnFlags,
	input wire logic           port2Wr,
	input wire kbhm_port2_s    port2Data,
	input wire logic [3:0]     kmPinOeN,
	input wire logic           coreHalt,
	input wire logic           aluRun
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	logic        fl;
	kbhm_port2_s pv;

	// Decoded host strobes
	wire rdD = hostReq.read && hostReq.addr == KBHM_DATA_PORT_ADDR;
	wire rdC = hostReq.read && hostReq.addr == KBHM_CTL_PORT_ADDR;
	wire wrD = hostReq.write && hostReq.addr == KBHM_DATA_PORT_ADDR;
	wire wrC = hostReq.write && hostReq.addr == KBHM_CTL_PORT_ADDR;

	// Shadow of flags mode and latched port bits
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fl <= 1'b0;
			pv <= '0;
		end else begin
			fl <= fl | coreEnFlags;
			pv <= port2Wr ? port2Data : pv;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_cmd_sets_cd: assert property (wrC |-> ##2 coreStatus[3] && coreStatus[1])
		else $error("command write flags wrong");
	chk_data_clr_cd: assert property (wrD |-> ##2 !coreStatus[3] && coreStatus[1])
		else $error("data write flags wrong");
	chk_status_read: assert property (rdC |=> hostRdData == coreStatus)
		else $error("status read wrong");
	chk_obf_set: assert property (coreWrOut |-> ##2 coreStatus[0])
		else $error("output full not set");
	chk_kbd_irq_out_direct: assert property ((!fl && !port2Wr) [*3] |-> kbd_irq_out == pv.port_bit_kbd_irq_out)
		else $error("keyboard irq not following port");
	chk_aux_irq_out_direct: assert property ((!fl && !port2Wr) [*3] |-> aux_irq_out == pv.port_bit_aux_irq_out)
		else $error("mouse irq not following port");
	chk_kbd_irq_out_gated: assert property ((fl && !port2Wr) [*3] |=> $past(kbd_irq_out) == (coreStatus[0] && pv.port_bit_kbd_irq_out))
		else $error("keyboard irq gating wrong");
	chk_read_clears: assert property (fl && rdD && !coreWrOut |=> !kbd_irq_out)
		else $error("data read kept keyboard irq");
	chk_a20_follow: assert property (!port2Wr [*3] |-> gateA20 == pv.port_bit_a20)
		else $error("gate a20 wrong");
	chk_pin_drive: assert property (!port2Wr [*3] |-> kmPinOeN == ~{pv.port_bit_msdat, pv.port_bit_msclk, pv.port_bit_kbdat, pv.port_bit_kbclk})
		else $error("pin drive not inverted");
	chk_halt_stops: assert property (coreHalt && !hostReq.write |=> !aluRun)
		else $error("halt did not stop");
	chk_write_wakes: assert property (!aluRun && (wrD || wrC) |=> aluRun)
		else $error("host write did not wake");

	cover property (fl && rdD);
	cover property (wrC);
	cover property (coreHalt);
endmodule

bind kbhm_mailbox kbhm_mailbox_asserts chk (.*);

//--- testbench/kbhm_host_model.sv
// Host side model issuing one-cycle I/O strobes to the mailbox.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/100ps

module kbhm_host_model
	import kbhm_pkg::*;
(
	input wire logic       clock,
	output kbhm_host_req_s hostReq,
	input wire logic [7:0] hostRdData
);
	initial hostReq = '0;

	// Write strobe, then scrambled idle bus and optional gap
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input int gap);
		hostReq <= '{1'b1, 1'b0, a, d};
		@(posedge clock);
		hostReq <= '{1'b0, 1'b0, ~a, ~d};
		@(posedge clock);
		repeat (gap) @(posedge clock);
	endtask

	// Read strobe, data taken one edge after the read edge
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		hostReq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		hostReq <= '{1'b0, 1'b0, ~a, 8'hFF};
		@(posedge clock);
		v = hostRdData;
	endtask
endmodule

//--- testbench/kbhm_mailbox_tb.sv
// Self-checking bench for the keyboard host mailbox.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/100ps

module kbhm_mailbox_tb
	import kbhm_pkg::*;
;
	localparam int P_WO = 0, P_RI = 1, P_SW = 2, P_OC = 3, P_EF = 4;
	localparam int P_P2 = 5, P_P1 = 6, P_TO = 7, P_HA = 8, P_ST = 9;
	logic           clock = 1'b0;
	logic           rst   = 1'b1;
	logic [9:0]     pls   = '0;
	logic [7:0]     coreWrData, coreStatusData, hostRdData;
	logic [7:0]     core_input_reg, coreStatus;
	logic [2:0]     port1Data, quasiOut, quasiOeN;
	logic [3:0]     kmPinIn, kmPinOut, kmPinOeN;
	logic           openDrainMode, ibfIrqEn, timerIrqEn;
	logic           coreWrOut, coreRdIn, coreStatusWr, coreObfClr;
	logic           coreEnFlags, port2Wr, port1Wr, timerOverflow;
	logic           coreHalt, coreStop, kbd_irq_out, aux_irq_out;
	logic           gateA20, coreIrqIbf, coreIrqTimer, wakeCall;
	logic           coreRestart, aluRun, timerRun, oscRun;
	logic           test_in_kbclk, port_in_kbdat;
	logic           test_in_msclk, port_in_msdat;
	kbhm_port2_s    port2Data;
	kbhm_host_req_s hostReq;
	int             bad_count = 0;
	int             checked = 0;
	int             cyc = 0;

	// Strobes and pulled-up open-drain pins
	assign {coreStop, coreHalt, timerOverflow, port1Wr, port2Wr,
		coreEnFlags, coreObfClr, coreStatusWr, coreRdIn, coreWrOut} = pls;
	assign kmPinIn = kmPinOeN | kmPinOut;

	kbhm_mailbox uut (.*);
	kbhm_host_model host (.clock(clock), .hostReq(hostReq),
		.hostRdData(hostRdData));

	always #50 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic pulse(input int i);
		pls[i] <= 1'b1;
		tick(1);
		pls[i] <= 1'b0;
	endtask

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic setp2(input logic [6:0] v);
		port2Data <= v;
		pulse(P_P2);
		tick(3);
	endtask

	task automatic qset(input logic [2:0] v, output logic [7:0] n);
		port1Data <= v;
		pulse(P_P1);
		n = 0;
		repeat (10) begin
			tick(1);
			n += 8'(quasiOut[0] && !quasiOeN[0]);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_mail();
		logic [7:0] v;
		host.rd(KBHM_CTL_PORT_ADDR, v);
		cmp(v, KBHM_STATUS_RST);
		cmp(kbd_irq_out, 8'h00);
		host.wr(KBHM_CTL_PORT_ADDR, 8'hA5, 0);
		host.rd(KBHM_CTL_PORT_ADDR, v);
		cmp(v, 8'h0A);
		cmp(core_input_reg, 8'hA5);
		host.wr(KBHM_DATA_PORT_ADDR, 8'h5A, 0);
		host.wr(16'h0061, 8'hFF, 0);
		host.rd(KBHM_CTL_PORT_ADDR, v);
		cmp(v, 8'h02);
		cmp(core_input_reg, 8'h5A);
		pulse(P_RI);
		coreStatusData <= 8'hFF;
		pulse(P_SW);
		host.rd(KBHM_CTL_PORT_ADDR, v);
		cmp(v, 8'hF4);
		$display("test mailbox done");
	endtask

	task automatic t_irq();
		logic [7:0] v;
		setp2(7'h18);
		cmp({kbd_irq_out, aux_irq_out}, 8'h03);
		coreWrData <= 8'h3C;
		pulse(P_WO);
		host.rd(KBHM_DATA_PORT_ADDR, v);
		cmp(v, 8'h3C);
		host.rd(KBHM_CTL_PORT_ADDR, v);
		cmp(v[0], 8'h01);
		setp2(7'h00);
		cmp({kbd_irq_out, aux_irq_out}, 8'h00);
		pulse(P_OC);
		pulse(P_EF);
		setp2(7'h18);
		cmp({kbd_irq_out, aux_irq_out}, 8'h01);
		coreWrData <= 8'h77;
		pulse(P_WO);
		tick(1);
		cmp(kbd_irq_out, 8'h01);
		host.wr(KBHM_DATA_PORT_ADDR, 8'h11, 2);
		cmp(aux_irq_out, 8'h00);
		host.rd(KBHM_DATA_PORT_ADDR, v);
		cmp(v, 8'h77);
		cmp(kbd_irq_out, 8'h00);
		pulse(P_WO);
		setp2(7'h10);
		cmp(kbd_irq_out, 8'h00);
		$display("test interrupts done");
	endtask

	task automatic t_pins();
		logic [7:0] n;
		setp2(7'h61);
		cmp(gateA20, 8'h01);
		cmp(kmPinOeN, 8'h0C);
		tick(6);
		cmp({test_in_kbclk, port_in_kbdat, test_in_msclk,
			port_in_msdat}, 8'h03);
		qset(3'h0, n);
		cmp({quasiOut, quasiOeN}, 8'h00);
		qset(3'h1, n);
		cmp(n, 8'(QUASI_DRIVE_CYC - 1));
		cmp(quasiOeN, 8'h01);
		openDrainMode <= 1'b1;
		qset(3'h0, n);
		cmp(quasiOeN, 8'h00);
		qset(3'h1, n);
		cmp({n[6:0], quasiOeN[0]}, 8'h01);
		$display("test pins done");
	endtask

	task automatic t_pwr();
		logic [7:0] v;
		ibfIrqEn <= 1'b1;
		timerIrqEn <= 1'b1;
		pulse(P_TO);
		tick(1);
		cmp(coreIrqTimer, 8'h01);
		pulse(P_RI);
		pulse(P_HA);
		tick(1);
		cmp({aluRun, timerRun}, 8'h01);
		host.wr(KBHM_DATA_PORT_ADDR, 8'h22, 0);
		cmp({wakeCall, aluRun, coreIrqIbf}, 8'h07);
		pulse(P_ST);
		tick(1);
		cmp({oscRun, aluRun}, 8'h00);
		host.wr(KBHM_CTL_PORT_ADDR, 8'h33, 1);
		cmp({oscRun, aluRun}, 8'h03);
		pulse(P_HA);
		rst <= 1'b1;
		tick(3);
		cmp({coreRestart, aluRun, kbd_irq_out}, 8'h06);
		rst <= 1'b0;
		tick(2);
		cmp(coreRestart, 8'h00);
		host.rd(KBHM_CTL_PORT_ADDR, v);
		cmp(v, 8'h00);
		$display("test power done");
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		coreWrData = '0;
		coreStatusData = '0;
		port1Data = '0;
		port2Data = '0;
		openDrainMode = 1'b0;
		ibfIrqEn = 1'b0;
		timerIrqEn = 1'b0;
		tick(10);
		rst <= 1'b0;
		t_mail();
		t_irq();
		t_pins();
		t_pwr();
		results();
	end
endmodule
